// ---- hw/secl_loader.sv ----
// Power-up loader: reads bytes 00 to 0E from the serial memory and
// holds the values that the host controller takes into its registers.
module secl_loader #(
  parameter logic [6:0] DEV_ADDR = secl_pkg::EEPROM_DEV_ADDR,
  parameter int QUARTER_CYC = secl_pkg::SCL_QUARTER_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Target access handshake from the bus side.
  input wire logic target_access_i,
  output logic target_retry_o,
  output logic target_accept_o,
  output logic load_busy_o,
  // Serial memory link.
  output logic scl_o,
  output logic sda_oe_n_o,
  input wire logic sda_i,
  // Loaded register values.
  output logic [31:0] unique_id_upper_o,
  output logic [31:0] unique_id_lower_o,
  output logic [15:0] subsystem_identifier_o,
  output logic [15:0] vendor_identifier_o,
  output logic [15:0] latency_and_grant_o,
  output logic controller_control_b23_o,
  output logic link_tuning_b7_o,
  output logic link_tuning_b2_o,
  output logic link_tuning_b1_o
);
  secl_pkg::secl_state_e state_r; // Step of the load.
  secl_pkg::secl_state_e state_nxt; // Next step.
  secl_pkg::secl_cmd_e cmd_w; // Command for the engine.
  logic [7:0] tx_w; // Byte to send.
  logic [3:0] idx_r; // Memory byte now being read.
  logic wait_r; // Command issued, waiting for its end.
  logic retry_r; // Address not acknowledged, start over.
  logic [7:0] mem_r [secl_pkg::NUM_BYTES]; // Loaded bytes.
  logic eng_done_w; // Engine finished a command.
  logic [7:0] rx_w; // Byte returned by a read.
  logic ack_bad_w; // Acknowledge bit was high.

  // Decode of the sequencer hand-shake with the engine.
  wire cmd_valid_w = !wait_r && (state_r != secl_pkg::ST_DONE);
  wire store_w = eng_done_w && (state_r == secl_pkg::ST_READ);
  wire last_w = (idx_r == secl_pkg::BYTE_LAST);
  wire addr_fail_w = eng_done_w && ack_bad_w &&
    ((state_r == secl_pkg::ST_DEVW) || (state_r == secl_pkg::ST_ADDR) ||
     (state_r == secl_pkg::ST_DEVR));

  // Bit engine that drives the link.
  secl_twi_engine #(
    .QUARTER_CYC(QUARTER_CYC)
  ) u_engine (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_w),
    .cmd_i(cmd_w),
    .tx_byte_i(tx_w),
    .nack_send_i(last_w),
    .done_o(eng_done_w),
    .rx_byte_o(rx_w),
    .ack_bad_o(ack_bad_w),
    .scl_o(scl_o),
    .sda_oe_n_o(sda_oe_n_o),
    .sda_i(sda_i)
  );

  // Sequence: start, device write, address, start, device read,
  // fifteen reads in order, stop.
  always_comb begin
    state_nxt = state_r;
    cmd_w = secl_pkg::CMD_START;
    tx_w = secl_pkg::EEPROM_FIRST_ADDR;
    case (state_r)
      secl_pkg::ST_START1: begin
        if (eng_done_w)
          state_nxt = secl_pkg::ST_DEVW;
      end
      secl_pkg::ST_DEVW: begin
        cmd_w = secl_pkg::CMD_WRITE;
        tx_w = {DEV_ADDR, secl_pkg::RW_WRITE};
        if (eng_done_w)
          state_nxt = ack_bad_w ? secl_pkg::ST_STOP : secl_pkg::ST_ADDR;
      end
      secl_pkg::ST_ADDR: begin
        // Reading starts from the first byte of the map.
        cmd_w = secl_pkg::CMD_WRITE;
        if (eng_done_w)
          state_nxt = ack_bad_w ? secl_pkg::ST_STOP : secl_pkg::ST_START2;
      end
      secl_pkg::ST_START2: begin
        if (eng_done_w)
          state_nxt = secl_pkg::ST_DEVR;
      end
      secl_pkg::ST_DEVR: begin
        cmd_w = secl_pkg::CMD_WRITE;
        tx_w = {DEV_ADDR, secl_pkg::RW_READ};
        if (eng_done_w)
          state_nxt = ack_bad_w ? secl_pkg::ST_STOP : secl_pkg::ST_READ;
      end
      secl_pkg::ST_READ: begin
        // Sequential read; the last byte is not acknowledged.
        cmd_w = secl_pkg::CMD_READ;
        if (store_w && last_w)
          state_nxt = secl_pkg::ST_STOP;
      end
      secl_pkg::ST_STOP: begin
        cmd_w = secl_pkg::CMD_STOP;
        if (eng_done_w)
          state_nxt = retry_r ? secl_pkg::ST_START1 : secl_pkg::ST_DONE;
      end
      secl_pkg::ST_DONE: begin
        cmd_w = secl_pkg::CMD_STOP;
      end
      default: begin
        state_nxt = secl_pkg::ST_START1;
      end
    endcase
  end

  // Step register; the load begins right after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_r <= secl_pkg::ST_START1;
    else
      state_r <= state_nxt;
  end

  // Issue one command at a time and wait for its end.
  always_ff @(posedge clk_i) begin
    if (rst_i)
      wait_r <= 1'b0;
    else if (cmd_valid_w)
      wait_r <= 1'b1;
    else if (eng_done_w)
      wait_r <= 1'b0;
  end

  // A refused address makes the whole read start again after a stop.
  always_ff @(posedge clk_i) begin
    if (rst_i)
      retry_r <= 1'b0;
    else if (addr_fail_w)
      retry_r <= 1'b1;
    else if (state_r == secl_pkg::ST_STOP && eng_done_w)
      retry_r <= 1'b0;
  end

  // Byte pointer climbs by one per stored byte before the last.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == secl_pkg::ST_START1)
      idx_r <= secl_pkg::IDX_RESET;
    else if (store_w && !last_w)
      idx_r <= idx_r + secl_pkg::IDX_STEP;
  end

  // Byte store; the reserved byte is never kept.
  for (genvar i = 0; i < secl_pkg::NUM_BYTES; i++) begin : g_byte
    if (i == int'(secl_pkg::BYTE_RSVD)) begin : g_rsvd
      // Reserved byte is read on the link and discarded.
      assign mem_r[i] = secl_pkg::BYTE_RESET;
    end else begin : g_keep
      always_ff @(posedge clk_i) begin
        if (rst_i)
          mem_r[i] <= secl_pkg::BYTE_RESET;
        else if (store_w && idx_r == 4'(i))
          mem_r[i] <= rx_w;
      end
    end
  end

  // Loaded fields, least significant byte first in each group.
  assign unique_id_upper_o = {
    mem_r[secl_pkg::BYTE_UIDH0 + 4'h3], mem_r[secl_pkg::BYTE_UIDH0 + 4'h2],
    mem_r[secl_pkg::BYTE_UIDH0 + 4'h1], mem_r[secl_pkg::BYTE_UIDH0]};
  assign unique_id_lower_o = {
    mem_r[secl_pkg::BYTE_UIDL0 + 4'h3], mem_r[secl_pkg::BYTE_UIDL0 + 4'h2],
    mem_r[secl_pkg::BYTE_UIDL0 + 4'h1], mem_r[secl_pkg::BYTE_UIDL0]};
  assign subsystem_identifier_o = {
    mem_r[secl_pkg::BYTE_SUB_HI], mem_r[secl_pkg::BYTE_SUB_LO]};
  assign vendor_identifier_o = {
    mem_r[secl_pkg::BYTE_VEN_HI], mem_r[secl_pkg::BYTE_VEN_LO]};
  // Upper nibble is maximum latency, lower nibble minimum grant.
  assign latency_and_grant_o = {
    secl_pkg::NIBBLE_PAD, mem_r[secl_pkg::BYTE_LATGNT][7:4],
    secl_pkg::NIBBLE_PAD, mem_r[secl_pkg::BYTE_LATGNT][3:0]};
  // Control byte bits.
  assign controller_control_b23_o =
    mem_r[secl_pkg::BYTE_CTRL][secl_pkg::BIT_HC23];
  assign link_tuning_b7_o =
    mem_r[secl_pkg::BYTE_CTRL][secl_pkg::BIT_UNFAIR];
  assign link_tuning_b2_o =
    mem_r[secl_pkg::BYTE_CTRL][secl_pkg::BIT_LNK2];
  assign link_tuning_b1_o =
    mem_r[secl_pkg::BYTE_CTRL][secl_pkg::BIT_LNK1];

  // Busy from reset until the last stop has ended.
  always_ff @(posedge clk_i) begin
    if (rst_i)
      load_busy_o <= 1'b1;
    else if (state_nxt == secl_pkg::ST_DONE)
      load_busy_o <= 1'b0;
  end

  // Target answers: retry while loading, accept afterwards.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_retry_o <= 1'b0;
      target_accept_o <= 1'b0;
    end else begin
      target_retry_o <= target_access_i && load_busy_o;
      target_accept_o <= target_access_i && !load_busy_o;
    end
  end

  // An access during the load is answered with retry next cycle.
  a_retry_busy: assert property (
    @(posedge clk_i) disable iff (rst_i)
    target_access_i && load_busy_o |=> target_retry_o && !target_accept_o)
    else $error("access during load not retried");

  // No access is completed before the load has ended.
  a_no_accept_busy: assert property (
    @(posedge clk_i) disable iff (rst_i)
    target_accept_o |-> !$past(load_busy_o))
    else $error("access accepted during load");

  // Busy only drops once the last byte has been stored.
  a_busy_after_all: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(load_busy_o) |-> idx_r == secl_pkg::BYTE_LAST)
    else $error("load ended before last byte");

  // Bytes are stored in ascending order.
  a_ascending_idx: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && !last_w |=> idx_r == $past(idx_r) + secl_pkg::IDX_STEP)
    else $error("byte pointer did not step by one");

  // Latency and grant follow byte 00.
  a_latency_fill: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && idx_r == secl_pkg::BYTE_LATGNT |=>
    latency_and_grant_o == {secl_pkg::NIBBLE_PAD, $past(rx_w[7:4]),
                            secl_pkg::NIBBLE_PAD, $past(rx_w[3:0])})
    else $error("latency and grant wrong");

  // Vendor high byte comes from byte 02.
  a_vendor_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && idx_r == secl_pkg::BYTE_VEN_HI |=>
    vendor_identifier_o[15:8] == $past(rx_w))
    else $error("vendor high byte wrong");

  // Lower id top byte comes from byte 0E, the last one read.
  a_uid_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && idx_r == secl_pkg::BYTE_LAST |=>
    unique_id_lower_o[31:24] == $past(rx_w))
    else $error("unique id byte order wrong");

  // Upper id low byte comes from byte 07.
  a_uid_low_first: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && idx_r == secl_pkg::BYTE_UIDH0 |=>
    unique_id_upper_o[7:0] == $past(rx_w))
    else $error("upper id low byte wrong");

  // Control byte bit 6 sets control bit 23, bit 7 the unfair enable.
  a_ctrl_bits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && idx_r == secl_pkg::BYTE_CTRL |=>
    controller_control_b23_o == $past(rx_w[secl_pkg::BIT_HC23]) &&
    link_tuning_b7_o == $past(rx_w[secl_pkg::BIT_UNFAIR]))
    else $error("control bits wrong");

  // Subsystem high byte comes from byte 04.
  a_subsys_high: assert property (
    @(posedge clk_i) disable iff (rst_i)
    store_w && idx_r == secl_pkg::BYTE_SUB_HI |=>
    subsystem_identifier_o[15:8] == $past(rx_w))
    else $error("subsystem high byte wrong");
endmodule : secl_loader

// ---- hw/secl_pkg.sv ----
// How it works
// - EEPROM reached only over clock and data wires.
// - Power-up load fills identifiers, latency, control bits.
// - Target accesses get retry while load runs.
// - Byte 00 fills latency and grant field.
// - Vendor id: byte 01 low, byte 02 high.
// - Unique id: bytes 07-0A upper, 0B-0E lower.
// - Byte 05 gives link bits 7,2,1, control 23.
// - Subsystem id: byte 03 low, byte 04 high.
package secl_pkg;
  // Timing of the serial clock derived from the system clock.
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QUARTER_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int DIV_W = 8;
  // Quarter phases of one serial bit.
  localparam logic [1:0] Q_SET = 2'h0;
  localparam logic [1:0] Q_SAMPLE = 2'h2;
  localparam logic [1:0] Q_LAST = 2'h3;
  // Nine bits per byte transfer, data plus acknowledge.
  localparam logic [3:0] BIT_LAST = 4'h8;
  // Serial memory addressing.
  localparam logic [6:0] EEPROM_DEV_ADDR = 7'h50;
  localparam logic [7:0] EEPROM_FIRST_ADDR = 8'h00;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  // Byte map of the serial memory.
  localparam int NUM_BYTES = 15;
  localparam logic [3:0] BYTE_LATGNT = 4'h0;
  localparam logic [3:0] BYTE_VEN_LO = 4'h1;
  localparam logic [3:0] BYTE_VEN_HI = 4'h2;
  localparam logic [3:0] BYTE_SUB_LO = 4'h3;
  localparam logic [3:0] BYTE_SUB_HI = 4'h4;
  localparam logic [3:0] BYTE_CTRL = 4'h5;
  localparam logic [3:0] BYTE_RSVD = 4'h6;
  localparam logic [3:0] BYTE_UIDH0 = 4'h7;
  localparam logic [3:0] BYTE_UIDL0 = 4'hB;
  localparam logic [3:0] BYTE_LAST = 4'hE;
  localparam logic [3:0] IDX_RESET = 4'h0;
  localparam logic [3:0] IDX_STEP = 4'h1;
  // Bit positions inside the control byte.
  localparam int BIT_UNFAIR = 7;
  localparam int BIT_HC23 = 6;
  localparam int BIT_LNK2 = 2;
  localparam int BIT_LNK1 = 1;
  // Padding of each latency and grant nibble.
  localparam logic [3:0] NIBBLE_PAD = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Offsets of the registers that the load fills.
  localparam logic [7:0] OFF_UID_UPPER = 8'h24;
  localparam logic [7:0] OFF_UID_LOWER = 8'h28;
  localparam logic [7:0] OFF_SUBSYS = 8'h2C;
  localparam logic [7:0] OFF_VENDOR = 8'h2D;
  localparam logic [7:0] OFF_LATGNT = 8'h3E;
  localparam logic [7:0] OFF_CTRL = 8'h50;
  localparam logic [7:0] OFF_LINK = 8'hF4;
  // Commands of the serial engine.
  typedef enum logic [3:0] {
    CMD_START = 4'h1,
    CMD_WRITE = 4'h2,
    CMD_READ = 4'h4,
    CMD_STOP = 4'h8
  } secl_cmd_e;
  // Steps of the load sequence.
  typedef enum logic [7:0] {
    ST_START1 = 8'h01,
    ST_DEVW = 8'h02,
    ST_ADDR = 8'h04,
    ST_START2 = 8'h08,
    ST_DEVR = 8'h10,
    ST_READ = 8'h20,
    ST_STOP = 8'h40,
    ST_DONE = 8'h80
  } secl_state_e;
endpackage : secl_pkg

// ---- hw/secl_twi_engine.sv ----
// Bit engine for the two-wire link: start, byte write, byte read, stop.
module secl_twi_engine #(
  parameter int QUARTER_CYC = secl_pkg::SCL_QUARTER_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Command side.
  input wire logic cmd_valid_i,
  input wire secl_pkg::secl_cmd_e cmd_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic nack_send_i,
  output logic done_o,
  output logic [7:0] rx_byte_o,
  output logic ack_bad_o,
  // Link pins.
  output logic scl_o,
  output logic sda_oe_n_o,
  input wire logic sda_i
);
  logic busy_r; // Command in progress.
  secl_pkg::secl_cmd_e op_r; // Current command.
  logic [secl_pkg::DIV_W-1:0] div_r; // Quarter timer.
  logic [1:0] q_r; // Quarter within a bit.
  logic [3:0] bit_r; // Bit within a byte.
  logic [8:0] sh_r; // Out bits, replaced by sampled bits.
  logic sda_meta_r; // First synchroniser stage.
  logic sda_sync_r; // Second synchroniser stage.
  logic scl_nxt;
  logic sda_nxt;

  // Decode of timer ends and command end.
  wire tick_w = busy_r &&
    (div_r == secl_pkg::DIV_W'(QUARTER_CYC - 1));
  wire is_bit_w = (op_r == secl_pkg::CMD_WRITE) ||
    (op_r == secl_pkg::CMD_READ);
  wire last_q_w = tick_w && (q_r == secl_pkg::Q_LAST);
  wire finish_w = last_q_w && (!is_bit_w || bit_r == secl_pkg::BIT_LAST);
  assign rx_byte_o = sh_r[8:1];
  assign ack_bad_o = sh_r[0];

  // Line levels for each quarter; data high means released.
  always_comb begin
    scl_nxt = scl_o;
    sda_nxt = sda_oe_n_o;
    if (busy_r) begin
      case (op_r)
        secl_pkg::CMD_START: begin
          scl_nxt = (q_r == 2'h1) || (q_r == secl_pkg::Q_SAMPLE);
          sda_nxt = (q_r < secl_pkg::Q_SAMPLE);
        end
        secl_pkg::CMD_STOP: begin
          scl_nxt = (q_r != secl_pkg::Q_SET);
          sda_nxt = (q_r >= secl_pkg::Q_SAMPLE);
        end
        default: begin
          scl_nxt = (q_r == 2'h1) || (q_r == secl_pkg::Q_SAMPLE);
          // The last quarter holds the line, so data never moves on the
          // same edge as the falling clock; the next bit shows in q0.
          sda_nxt = (q_r == secl_pkg::Q_LAST) ? sda_oe_n_o : sh_r[8];
        end
      endcase
    end
  end

  // Two-stage synchroniser for the data line.
  always_ff @(posedge clk_i) begin
    sda_meta_r <= sda_i;
    sda_sync_r <= sda_meta_r;
  end

  // Pin registers; data pulls low only, never drives high.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      scl_o <= scl_nxt;
      sda_oe_n_o <= sda_nxt;
    end
  end

  // Command sequencing and bit timing.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
      op_r <= secl_pkg::CMD_STOP;
      div_r <= '0;
      q_r <= secl_pkg::Q_SET;
      bit_r <= '0;
      sh_r <= '1;
      done_o <= 1'b0;
    end else begin
      done_o <= finish_w;
      div_r <= tick_w || !busy_r ? '0 : div_r + 1'b1;
      if (!busy_r && cmd_valid_i) begin
        busy_r <= 1'b1;
        op_r <= cmd_i;
        q_r <= secl_pkg::Q_SET;
        bit_r <= '0;
        sh_r <= (cmd_i == secl_pkg::CMD_READ) ?
          {8'hFF, nack_send_i} : {tx_byte_i, 1'b1};
      end else if (tick_w) begin
        q_r <= q_r + 1'b1;
        if (is_bit_w && q_r == secl_pkg::Q_SAMPLE)
          sh_r <= {sh_r[7:0], sda_sync_r};
        if (last_q_w)
          bit_r <= bit_r + 1'b1;
        if (finish_w)
          busy_r <= 1'b0;
      end
    end
  end

  // While a read shifts data bits the engine keeps the line released.
  a_read_release: assert property (
    @(posedge clk_i) disable iff (rst_i)
    busy_r && op_r == secl_pkg::CMD_READ && bit_r < secl_pkg::BIT_LAST
    && q_r == secl_pkg::Q_SAMPLE |=> sda_oe_n_o)
    else $error("data line driven during read data bit");
endmodule : secl_twi_engine

// ---- test/secl_eeprom_model.sv ----
// Behavioural serial memory that answers the loader on the two-wire link.
module secl_eeprom_model (
  // Link wires as seen on the board.
  input wire logic scl_i,
  input wire logic sda_i,
  // Memory contents and a switch that refuses the device address.
  input wire logic [119:0] mem_i,
  input wire logic nack_dev_i,
  // Board reset, which also leaves the memory's interface idle.
  input wire logic rst_i,
  // Pull-down request on the data line and count of acknowledged bytes.
  output logic pull_low_o,
  output logic [4:0] acked_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int bitn; // Bit slot inside the current nine-bit unit.
  logic [7:0] sh; // Bits received from the master.
  logic [3:0] ptr; // Byte pointer into the memory.
  logic sending; // High while the memory returns data.
  logic is_dev; // High for the first byte after a start.
  logic live; // High between a start and a stop.
  logic m_ack; // Acknowledge sampled from the master.
  initial begin
    pull_low_o = 1'b0;
    acked_o = 5'h00;
    live = 1'b0;
    sending = 1'b0;
  end
  // A board reset drops any cut frame and releases the data line.
  always @(posedge rst_i) begin
    live = 1'b0;
    sending = 1'b0;
    pull_low_o = 1'b0;
  end
  // A start restarts framing and the byte count.
  always @(negedge sda_i) begin
    if (scl_i) begin
      live = 1'b1;
      sending = 1'b0;
      is_dev = 1'b1;
      bitn = -1;
      acked_o = 5'h00;
    end
  end
  // A stop ends the frame and lets the pull-up take the line.
  always @(posedge sda_i) begin
    if (scl_i) begin
      live = 1'b0;
      pull_low_o = 1'b0;
    end
  end
  // Bits are taken while the clock is high.
  always @(posedge scl_i) begin
    if (live && !sending && bitn < 8) sh = {sh[6:0], sda_i};
    if (live && sending && bitn == 8) m_ack = !sda_i;
  end
  // The line changes only while the clock is low, data MSB first.
  always @(negedge scl_i) begin
    if (live) begin
      bitn = bitn + 1;
      if (!sending) begin
        if (bitn == 8) begin
          if (!is_dev) ptr = sh[3:0];
          pull_low_o = !is_dev || (!nack_dev_i && sh[7:1] == 7'h50);
        end else if (bitn == 9) begin
          bitn = 0;
          sending = is_dev && sh[0] && !nack_dev_i;
          is_dev = 1'b0;
          pull_low_o = sending && !mem_i[ptr * 8 + 7];
        end
      end else if (bitn < 8) begin
        pull_low_o = !mem_i[ptr * 8 + 7 - bitn];
      end else if (bitn == 8) begin
        pull_low_o = 1'b0; // Released for the master's acknowledge.
      end else begin
        bitn = 0;
        // Only an acknowledged byte moves the pointer on.
        if (m_ack) begin
          acked_o = acked_o + 5'h01;
          ptr = ptr + 4'h1;
          pull_low_o = !mem_i[ptr * 8 + 7];
        end else begin
          sending = 1'b0;
        end
      end
    end
  end
endmodule : secl_eeprom_model

// ---- test/secl_loader_bench.sv ----
// Self-checking bench: power-up load, refused address, retries, resets.
module secl_loader_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, target_access_i, nack_dev, busy_d, pull_low;
  logic target_retry_o, target_accept_o, load_busy_o, scl_o, sda_oe_n_o;
  logic sda; // Board data line with its pull-up.
  logic [31:0] uid_hi, uid_lo;
  logic [15:0] sub_id, ven_id, lat_gnt;
  logic b23, b7, b2, b1;
  logic [119:0] mem; // Memory image, byte k at bits 8k+7..8k.
  logic [4:0] acked;
  logic exp_resp_q[$]; // One note per access: 1 accept, 0 retry.
  logic [31:0] exp_val_q[$]; // Notes for the loaded values.
  int num_errors, cmp_count, seed, phase;
  assign sda = sda_oe_n_o & ~pull_low;
  secl_loader #(.QUARTER_CYC(2)) u_secl_loader (
    .clk_i(clk_i), .rst_i(rst_i), .target_access_i(target_access_i),
    .target_retry_o(target_retry_o), .target_accept_o(target_accept_o),
    .load_busy_o(load_busy_o), .scl_o(scl_o), .sda_oe_n_o(sda_oe_n_o),
    .sda_i(sda), .unique_id_upper_o(uid_hi), .unique_id_lower_o(uid_lo),
    .subsystem_identifier_o(sub_id), .vendor_identifier_o(ven_id),
    .latency_and_grant_o(lat_gnt), .controller_control_b23_o(b23),
    .link_tuning_b7_o(b7), .link_tuning_b2_o(b2), .link_tuning_b1_o(b1));
  secl_eeprom_model u_secl_eeprom_model (
    .scl_i(scl_o), .sda_i(sda), .mem_i(mem), .nack_dev_i(nack_dev),
    .rst_i(rst_i),
    .pull_low_o(pull_low), .acked_o(acked));
  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Counts a comparison and reports a mismatch at once.
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  // Compares an access answer as {retry, accept}.
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t answer %b expected %b", $time, got, exp);
    end
  endtask : cmp_resp
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Fresh random image; the expected register values are noted at once.
  task automatic fill();
    logic [7:0] m [15];
    for (int k = 0; k < 15; k++) begin
      m[k] = 8'($random(seed));
      mem[8 * k +: 8] = m[k];
    end
    exp_val_q.push_back({m[10], m[9], m[8], m[7]});
    exp_val_q.push_back({m[14], m[13], m[12], m[11]});
    exp_val_q.push_back({m[4], m[3], m[2], m[1]});
    exp_val_q.push_back({20'h00000, m[0][7:4], 4'h0, m[0][3:0]});
    exp_val_q.push_back({28'h0000000, m[5][6], m[5][7], m[5][2], m[5][1]});
  endtask : fill
  // Bounded wait: 0 a stop on the link, 1 fourteen acked bytes, 2 idle.
  task automatic wait_until(input int what);
    logic hit;
    logic sda_d;
    sda_d = sda;
    for (int n = 0; n < 20000; n++) begin
      @(posedge clk_i);
      hit = (what == 0) ? (scl_o && sda && !sda_d) :
            (what == 1) ? (acked == 5'h0E) : (load_busy_o === 1'b0);
      sda_d = sda;
      if (hit === 1'b1) return;
    end
    num_errors++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish();
  endtask : wait_until
  // Random accesses, back to back at times; each one gets a note.
  always @(posedge clk_i) begin
    if (phase != 0 && $random(seed) % 2 != 0) begin
      target_access_i <= 1'b1;
      exp_resp_q.push_back(phase == 2);
    end else begin
      target_access_i <= 1'b0;
    end
  end
  // Every answer takes the oldest note off the queue.
  always @(posedge clk_i) begin
    if (target_retry_o === 1'b1 || target_accept_o === 1'b1) begin
      if (exp_resp_q.size() == 0) begin
        cmp_resp({target_retry_o, target_accept_o}, 2'h0);
      end else begin
        cmp_resp({target_retry_o, target_accept_o},
                 exp_resp_q[0] ? 2'h1 : 2'h2);
        void'(exp_resp_q.pop_front());
      end
    end
  end
  // The end of a load takes the five value notes off the queue.
  always @(posedge clk_i) begin
    busy_d <= load_busy_o;
    if (busy_d === 1'b1 && load_busy_o === 1'b0) begin
      cmp_val(32'(exp_val_q.size()), 32'h5);
      cmp_val(uid_hi, exp_val_q.pop_front());
      cmp_val(uid_lo, exp_val_q.pop_front());
      cmp_val({sub_id, ven_id}, exp_val_q.pop_front());
      cmp_val({16'h0000, lat_gnt}, exp_val_q.pop_front());
      cmp_val({28'h0000000, b23, b7, b2, b1}, exp_val_q.pop_front());
      cmp_val({27'h0000000, acked}, 32'hE);
    end
  end
  // Main sequence.
  initial begin
    seed = 64;
    rst_i = 1'b1;
    nack_dev = 1'b1;
    phase = 0;
    mem = '0;
    fill();
    repeat (10) @(posedge clk_i);
    // Idle link, busy and cleared values while reset is held.
    cmp_val({29'h0, scl_o, sda_oe_n_o, load_busy_o}, 32'h7);
    cmp_val(uid_hi | uid_lo, 32'h0);
    rst_i <= 1'b0;
    phase <= 1;
    // The first try meets a refused address and must start again.
    wait_until(0);
    cmp_val({31'h0, load_busy_o}, 32'h1);
    nack_dev <= 1'b0;
    wait_until(1);
    phase <= 0;
    wait_until(2);
    repeat (2) @(posedge clk_i);
    // Once loaded, accesses complete.
    phase <= 2;
    repeat (200) @(posedge clk_i);
    phase <= 0;
    repeat (4) @(posedge clk_i);
    // New image, reset, then a second reset in the middle of the load.
    fill();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (600) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp_val({16'h0000, lat_gnt}, 32'h0);
    rst_i <= 1'b0;
    phase <= 1;
    wait_until(1);
    phase <= 0;
    wait_until(2);
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule : secl_loader_bench
